// File: core/dtw_pkg.sv
// Package of constants and types for the debug test port watch/bypass block
package dtw_pkg;

  // Width of the watch control data register
  localparam int unsigned WDC_W         = 8;
  // Watch-to-debug enable bit position and reset value
  localparam int unsigned WDC_EN_BIT    = 0;
  localparam logic [7:0]  WDC_RST       = 8'h00;
  // Bypass cell reset value
  localparam logic        BYP_RST       = 1'b0;
  // Debug exception code for a converted watch hit
  localparam logic [4:0]  DBG_CODE_WATCH = 5'h17;
  // Instruction register width and reset value (selects bypass)
  localparam int unsigned IR_W          = 5;
  localparam logic [4:0]  IR_RST        = 5'h1f;
  // Instruction codes: watch control and bypass
  localparam logic [4:0]  INS_WATCH     = 5'h1c;
  localparam logic [4:0]  INS_BYPASS    = 5'h1f;
  // Test clock limit: period at least four system clocks
  localparam int unsigned TCK_MIN_CYC   = 4;

  // Controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } dtw_tap_st_t;

  // Watch event from the processor core
  typedef struct packed {
    logic        hit;      // Watch match
    logic [31:0] pc;       // Faulting program counter
  } dtw_watch_t;

  // Exception result toward the core
  typedef struct packed {
    logic        dbg_exc;  // Debug exception taken
    logic        nrm_exc;  // Ordinary watch exception taken
    logic [4:0]  code;     // Debug exception code
  } dtw_exc_t;

endpackage

// File: core/dtw_tap.sv
// Test access port with watch control and bypass data registers
`timescale 1ns/1ns
// Summary of operation
// - Enable bit at bit 0, resets 0
// - Enable set: block watch writes outside debug
// - Enable set: watch hit becomes debug exception 23
// - Debug watch saves PC into debug return PC
// - Debug watch leaves Status, Cause, return PC
// - Bits 7:1 read-only zero
// - One-bit bypass gives shortest serial path
// - Bypass ignores writes, resets 0, reads zero
// - Sample data input on test clock rise
// - Data output changes on test clock fall
// - Mode select on rise advances controller
// - Debug mode indicator on its own output, not in the register
module dtw_tap
  import dtw_pkg::*;
(
  // System
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Probe pins
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  input  wire logic        ntrst_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  // Core side
  input  wire logic        debug_mode_i,
  input  wire logic        watch_wr_i,
  input  wire dtw_watch_t  watch_i,
  output logic             watch_wr_o,
  output dtw_exc_t         exc_o,
  output logic [31:0]      debug_return_pc_o,
  output logic             erpc_wr_o,
  output logic             debug_mode_indicator_o
);

  // Two-stage synchronisers for probe pins
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic       tck_d_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_ff    <= 4'h0;
      s2_ff    <= 4'h0;
      tck_d_ff <= 1'b0;
    end else begin
      s1_ff    <= {ntrst_i, tms_i, tdi_i, tck_i};
      s2_ff    <= s1_ff;
      tck_d_ff <= s2_ff[0];
    end
  end

  logic tck_s, tdi_s, tms_s, trst_s, tck_rise, tck_fall;
  assign tck_s    = s2_ff[0];
  assign tdi_s    = s2_ff[1];
  assign tms_s    = s2_ff[2];
  assign trst_s   = ~s2_ff[3];
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;

  // Controller state; test reset is caught on the system clock, since the
  // test clock may stand still while the probe holds reset
  dtw_tap_st_t st_ff;
  dtw_tap_st_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_RESET:  nxt_st = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   nxt_st = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_st = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_st = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nxt_st = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_st = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_st = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_st = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_st = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_st = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: nxt_st = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nxt_st = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_st = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_st = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_st = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_st = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   nxt_st = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || trst_s) begin
      st_ff <= ST_RESET;
    end else if (tck_rise) begin
      st_ff <= nxt_st;
    end
  end

  // Instruction register: shift and update
  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] ir_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || trst_s || (st_ff == ST_RESET)) begin
      ir_sh_ff <= IR_RST;
      ir_ff    <= IR_RST;
    end else if (tck_rise) begin
      if (st_ff == ST_CAP_IR) begin
        ir_sh_ff <= 5'h01;  // Fixed capture pattern
      end else if (st_ff == ST_SH_IR) begin
        ir_sh_ff <= {tdi_s, ir_sh_ff[IR_W-1:1]};
      end else if (st_ff == ST_UPD_IR) begin
        ir_ff <= ir_sh_ff;
      end
    end
  end

  // Watch control shift stage and held value
  logic             sel_watch;
  logic [WDC_W-1:0] wdc_sh_ff;
  logic             wdc_en_ff;
  assign sel_watch = (ir_ff == INS_WATCH);

  // watch register capture, shift, update
  // Bits 7:1 capture zero, so a probe write there never reads back
  always_ff @(posedge clk_i) begin
    if (!nrst_i || trst_s) begin
      wdc_sh_ff <= WDC_RST;
    end else if (tck_rise && sel_watch) begin
      if (st_ff == ST_CAP_DR) begin
        wdc_sh_ff <= {7'h00, wdc_en_ff};
      end else if (st_ff == ST_SH_DR) begin
        wdc_sh_ff <= {tdi_s, wdc_sh_ff[WDC_W-1:1]};
      end
    end
  end

  // enable bit; only bit 0 is writable
  always_ff @(posedge clk_i) begin
    if (!nrst_i || trst_s) begin
      wdc_en_ff <= WDC_RST[WDC_EN_BIT];
    end else if (tck_rise && sel_watch && (st_ff == ST_UPD_DR)) begin
      wdc_en_ff <= wdc_sh_ff[WDC_EN_BIT];
    end
  end

  // bypass cell: captures zero, never loaded by update
  logic byp_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || trst_s) begin
      byp_ff <= BYP_RST;
    end else if (tck_rise) begin
      if (st_ff == ST_CAP_DR) begin
        byp_ff <= BYP_RST;
      end else if (st_ff == ST_SH_DR) begin
        byp_ff <= tdi_s;
      end
    end
  end

  // data output moves only on the falling test clock edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i || trst_s) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= (st_ff == ST_SH_DR) || (st_ff == ST_SH_IR);
      if (st_ff == ST_SH_IR) begin
        tdo_o <= ir_sh_ff[0];
      end else if (sel_watch) begin
        tdo_o <= wdc_sh_ff[0];
      end else begin
        tdo_o <= byp_ff;
      end
    end
  end

  // Core side: write gating, exception steering, return PC capture
  logic blk_wr;
  assign blk_wr = wdc_en_ff & ~debug_mode_i;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      watch_wr_o             <= 1'b0;
      exc_o                  <= '0;
      debug_return_pc_o      <= 32'h0000_0000;
      erpc_wr_o              <= 1'b0;
      debug_mode_indicator_o <= 1'b0;
    end else begin
      watch_wr_o             <= watch_wr_i & ~blk_wr;  // Dropped, no fault raised
      exc_o.dbg_exc          <= watch_i.hit & wdc_en_ff;
      exc_o.nrm_exc          <= watch_i.hit & ~wdc_en_ff;
      exc_o.code             <= (watch_i.hit & wdc_en_ff) ? DBG_CODE_WATCH : 5'h00;
      erpc_wr_o              <= watch_i.hit & ~wdc_en_ff;  // Status, Cause, return PC kept on a debug watch
      debug_mode_indicator_o <= debug_mode_i;
      if (watch_i.hit && wdc_en_ff) begin
        debug_return_pc_o <= watch_i.pc;
      end
    end
  end

  // Assertions
  // a_wr_blocked
  a_wr_blocked: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (watch_wr_i && wdc_en_ff && !debug_mode_i) |=> !watch_wr_o)
    else $error("watch write passed while blocked");
  a_wr_pass: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (watch_wr_i && !(wdc_en_ff && !debug_mode_i)) |=> watch_wr_o)
    else $error("allowed watch write lost");
  a_dbg_code: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (watch_i.hit && wdc_en_ff) |=> (exc_o.dbg_exc && exc_o.code == 5'h17))
    else $error("debug exception code wrong");
  a_pc_saved: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (watch_i.hit && wdc_en_ff) |=> debug_return_pc_o == $past(watch_i.pc))
    else $error("debug return pc not saved");
  a_erpc_kept: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (watch_i.hit && wdc_en_ff) |=> (!erpc_wr_o && !exc_o.nrm_exc))
    else $error("ordinary return pc touched");
  a_en_reset: assert property (@(posedge clk_i)
    (!nrst_i || trst_s) |=> !wdc_en_ff)
    else $error("enable bit not reset");
  a_tdo_fall: assert property (@(posedge clk_i) disable iff (!nrst_i || trst_s)
    !tck_fall |=> $stable(tdo_o))
    else $error("tdo moved off falling edge");
  a_st_hold: assert property (@(posedge clk_i) disable iff (!nrst_i || trst_s)
    !tck_rise |=> $stable(st_ff))
    else $error("state moved without rise");
  a_trst_rst: assert property (@(posedge clk_i)
    trst_s |=> st_ff == ST_RESET)
    else $error("test reset ignored");
  a_ro_bits: assert property (@(posedge clk_i) disable iff (!nrst_i || trst_s)
    (tck_rise && sel_watch && st_ff == ST_CAP_DR) |=> wdc_sh_ff[7:1] == 7'h00)
    else $error("reserved bits not zero");

  // Main scenarios
  c_dbg_watch: cover property (@(posedge clk_i) exc_o.dbg_exc);
  c_blocked:   cover property (@(posedge clk_i) watch_wr_i && blk_wr);
  c_en_set:    cover property (@(posedge clk_i) $rose(wdc_en_ff));
  c_byp_shift: cover property (@(posedge clk_i) !sel_watch && st_ff == ST_SH_DR && tck_rise);

endmodule

// File: bench/dtw_probe.sv
// Debug probe model driving the test port pins
`timescale 1ns/1ns
module dtw_probe (
  // Pins toward the port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      ntrst_o,
  // Pins from the port
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic oe_seen;
  // Idle pins; test clock stands still between frames
  initial begin
    tck_o   = 1'b0;
    tms_o   = 1'b1;
    tdi_o   = 1'b0;
    ntrst_o = 1'b1;
    oe_seen = 1'b0;
  end
  task automatic tick(input logic t, input logic d, output logic q);
    tms_o = t;
    tdi_o = d;
    #62;
    tck_o = 1'b1;
    q = tdo_i;          // Output settled since the last fall
    oe_seen = tdo_oe_i;
    #63;
    tck_o = 1'b0;
  endtask
  task automatic reset_tap();
    logic b;
    #3;                 // Keep pin changes off the system clock edge
    ntrst_o = 1'b0;
    #100;
    ntrst_o = 1'b1;
    #100;
    tick(1'b0, 1'b0, b);
  endtask
  // walk to shift, scan LSB first, update
  task automatic scan(input logic ir, input logic [7:0] v, input int n,
                      output logic [7:0] q, output logic oe);
    logic b;
    q  = 8'h00;
    oe = 1'b1;
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, v[i], b);
      q[i] = b;
      oe &= oe_seen;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask
endmodule

// File: bench/dtw_tap_tb.sv
// Self-checking bench for the watch control and bypass port
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module dtw_tap_tb
  import dtw_pkg::*;
;
  typedef struct packed {logic wr; dtw_exc_t exc; logic erpc; logic [31:0] dpc;} dtw_note_t;
  logic clk_i, nrst_i, tck, tms, tdi, ntrst, tdo, tdo_oe, debug_mode_i, watch_wr_i;
  logic watch_wr_o, erpc_wr_o, dmi_o;
  logic [31:0] dpc_o, dpc_exp;
  dtw_watch_t watch_i;
  dtw_exc_t exc_o;
  dtw_note_t notes[$];
  dtw_note_t got;
  dtw_note_t exp_n;
  int miscompares, comparisons;
  logic [7:0] v, q;
  logic oe;
  dtw_tap dtw_tap_inst (.clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .ntrst_i(ntrst), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .debug_mode_i(debug_mode_i),
    .watch_wr_i(watch_wr_i), .watch_i(watch_i), .watch_wr_o(watch_wr_o), .exc_o(exc_o),
    .debug_return_pc_o(dpc_o), .erpc_wr_o(erpc_wr_o), .debug_mode_indicator_o(dmi_o));
  dtw_probe dtw_probe_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .ntrst_o(ntrst),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  // Single verdict point
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One core request; debug mode moves with the request so each answer has one cause
  task automatic core(input logic wr, input logic hit, input logic en, input logic dm);
    dtw_note_t n;
    logic [31:0] pc;
    pc = $urandom;
    @(posedge clk_i);
    debug_mode_i <= dm;
    watch_wr_i <= wr;
    watch_i <= '{hit: hit, pc: pc};
    n.wr = wr & ~(en & ~dm);
    n.exc = '{dbg_exc: hit & en, nrm_exc: hit & ~en, code: (hit & en) ? DBG_CODE_WATCH : 5'h00};
    if (hit & en) dpc_exp = pc;
    n.dpc = dpc_exp;
    n.erpc = hit & ~en;
    notes.push_back(n);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Watcher: answer lands on the edge that takes the request, read at the next fall
  initial forever begin
    @(posedge clk_i);
    if (watch_wr_i || watch_i.hit) begin
      @(negedge clk_i);
      got = {watch_wr_o, exc_o, erpc_wr_o, dpc_o};
      if (notes.size() == 0) begin
        miscompares++;
        $display("CHECK FAILED core answer exp a note got none");
      end else begin
        // Pop once; the macro names its expected value twice
        exp_n = notes.pop_front();
        `CHK("core answer", exp_n, got)
      end
    end
  end
  // Hang guard
  initial begin
    #1000000;
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(80099));
    {nrst_i, debug_mode_i, watch_wr_i, watch_i, dpc_exp} = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    dtw_probe_inst.reset_tap();
    v = $urandom;
    dtw_probe_inst.scan(1'b0, v, 8, q, oe);
    `CHK("bypass path", {v[6:0], 1'b0}, q)
    `CHK("shift enable", 1'b1, oe)
    @(posedge clk_i) debug_mode_i <= 1'b1;
    dtw_probe_inst.scan(1'b1, {3'h0, INS_WATCH}, 5, q, oe);
    `CHK("ir capture", 8'h01, q)
    dtw_probe_inst.scan(1'b0, 8'hff, 8, q, oe);
    `CHK("watch capture", 8'h00, q)
    `CHK("mode indicator", 1'b1, dmi_o)
    dtw_probe_inst.scan(1'b0, 8'h01, 8, q, oe);
    `CHK("read-only bits", 8'h01, q)
    core(1'b1, 1'b0, 1'b1, 1'b1);
    core(1'b1, 1'b0, 1'b1, 1'b0);
    core(1'b0, 1'b1, 1'b1, 1'b0);
    core(1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clk_i) {watch_wr_i, watch_i} <= '0;
    dtw_probe_inst.scan(1'b0, 8'h00, 8, q, oe);
    `CHK("enable set", 8'h01, q)
    `CHK("mode indicator", 1'b0, dmi_o)
    core(1'b0, 1'b1, 1'b0, 1'b0);
    core(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clk_i) {watch_wr_i, watch_i} <= '0;
    dtw_probe_inst.scan(1'b0, 8'h01, 8, q, oe);
    `CHK("enable clear", 8'h00, q)
    dtw_probe_inst.reset_tap();
    dtw_probe_inst.scan(1'b1, {3'h0, INS_WATCH}, 5, q, oe);
    dtw_probe_inst.scan(1'b0, 8'h00, 8, q, oe);
    `CHK("test reset", 8'h00, q)
    repeat (4) @(posedge clk_i);
    `CHK("pending notes", 0, notes.size())
    wrap_up();
  end
endmodule
